/* File: rtl/iva_vector_assign.sv */
// interrupt vector assignment: request merging, selection, address and dma routing
`timescale 1ns/1ps
`default_nettype none
module iva_vector_assign (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic [31:0] vector_table_base_in,
	input wire logic [47:0][4:0] level_control_in,
	input wire logic [59:0] src_req_in,
	input wire logic [59:0] src_enable_in,
	input wire logic fpu_exc_in,
	input wire logic inst_prot_in,
	input wire logic data_prot_in,
	input wire logic data_err_in,
	input wire logic emulator_trap_instruction_in,
	input wire logic inst_break_in,
	input wire logic illegal_inst_in,
	input wire logic user_mode_in,
	input wire logic sysreg_access_in,
	input wire logic nmi_req_in,
	input wire logic xbs_dbl_err_in,
	input wire logic bak_dbl_err_in,
	input wire logic swi_req_in,
	input wire logic [7:0] swi_num_in,
	output logic irq_valid_out,
	output logic [7:0] irq_vector_out,
	output logic [4:0] irq_level_out,
	output logic [31:0] irq_addr_out,
	output logic irq_resnum_valid_out,
	output logic [5:0] dma_resource_number_out,
	output logic [47:0] vec_req_out,
	output logic [47:0] dma_req_out
);
	import iva_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	iva_state_t q;
	iva_state_t d;

	logic [47:0] vec_req_c;
	logic [47:0] dma_req_c;
	logic pick_found;
	logic [5:0] pick_index;
	logic [4:0] pick_level;
	logic sysreg_fault;
	logic nmi_group;
	logic swi_ok;

	// ----------------------------------------------------------------
	// source merging onto shared vectors
	// ----------------------------------------------------------------
	always_comb begin
		vec_req_c = '0;
		dma_req_c = '0;
		for (int i = 0; i < IVA_NUM_SRC; i++) begin
			if (src_req_in[i] && src_enable_in[i]) begin
				vec_req_c[iva_src_vidx(i)] = 1'b1;
				if (iva_src_dma(i)) begin
					dma_req_c[iva_src_vidx(i)] = 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// peripheral arbitration
	// ----------------------------------------------------------------
	iva_level_select u_level_select (
		.req_in(vec_req_c),
		.level_in(level_control_in),
		.found_out(pick_found),
		.index_out(pick_index),
		.level_out(pick_level)
	);

	// ----------------------------------------------------------------
	// exception conditions
	// ----------------------------------------------------------------
	assign sysreg_fault = user_mode_in && sysreg_access_in;
	assign nmi_group = nmi_req_in || xbs_dbl_err_in || bak_dbl_err_in;
	assign swi_ok = swi_req_in && (swi_num_in >= IVA_VEC_SWI_FIRST);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		d = IVA_STATE_RST;
		d.vec_req = vec_req_c;
		d.dma_req = dma_req_c;
		d.valid = 1'b1;
		d.lvl = IVA_LVL_NONE;
		d.resnum_valid = 1'b0;
		d.resnum = 6'h00;
		if (fpu_exc_in) begin
			d.vec = IVA_VEC_FPU;
		end else if (inst_prot_in) begin
			d.vec = IVA_VEC_INST_PROT;
		end else if (data_prot_in) begin
			d.vec = IVA_VEC_DATA_PROT;
		end else if (data_err_in) begin
			d.vec = IVA_VEC_DATA_ERR;
		end else if (emulator_trap_instruction_in) begin
			d.vec = IVA_VEC_EMU_TRAP;
		end else if (inst_break_in) begin
			d.vec = IVA_VEC_INST_BRK;
		end else if (illegal_inst_in || sysreg_fault) begin
			d.vec = IVA_VEC_ILLEGAL;
		end else if (nmi_group) begin
			d.vec = IVA_VEC_NMI;
			d.lvl = IVA_LVL_NMI;
		end else if (pick_found) begin
			d.vec = IVA_VEC_PERIPH_FIRST + {2'b00, pick_index};
			d.lvl = pick_level;
			d.resnum_valid = IVA_RESNUM_MASK[pick_index];
			d.resnum = pick_index;
		end else if (swi_ok) begin
			d.vec = swi_num_in;
		end else begin
			d.valid = 1'b0;
			d.vec = 8'h00;
		end
		d.addr = vector_table_base_in + {22'h000000, iva_offset(d.vec)};
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			q <= IVA_STATE_RST;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign irq_valid_out = q.valid;
	assign irq_vector_out = q.vec;
	assign irq_level_out = q.lvl;
	assign irq_addr_out = q.addr;
	assign irq_resnum_valid_out = q.resnum_valid;
	assign dma_resource_number_out = q.resnum;
	assign vec_req_out = q.vec_req;
	assign dma_req_out = q.dma_req;

endmodule // iva_vector_assign
`default_nettype wire

/* File: rtl/iva_pkg.sv */
// constants, types and helper functions of the interrupt vector assignment block
package iva_pkg;

	// ----------------------------------------------------------------
	// vector numbering
	// ----------------------------------------------------------------
	localparam logic [7:0] IVA_VEC_FPU = 8'h05;
	localparam logic [7:0] IVA_VEC_INST_PROT = 8'h06;
	localparam logic [7:0] IVA_VEC_DATA_PROT = 8'h07;
	localparam logic [7:0] IVA_VEC_DATA_ERR = 8'h08;
	localparam logic [7:0] IVA_VEC_EMU_TRAP = 8'h09;
	localparam logic [7:0] IVA_VEC_INST_BRK = 8'h0A;
	localparam logic [7:0] IVA_VEC_ILLEGAL = 8'h0E;
	localparam logic [7:0] IVA_VEC_NMI = 8'h0F;
	localparam logic [7:0] IVA_VEC_PERIPH_FIRST = 8'h10;
	localparam logic [7:0] IVA_VEC_SWI_FIRST = 8'h42;

	// ----------------------------------------------------------------
	// levels, offsets, sizes
	// ----------------------------------------------------------------
	localparam int IVA_NUM_PVEC = 48;
	localparam int IVA_NUM_SRC = 60;
	localparam logic [4:0] IVA_LVL_NMI = 5'h0F;
	localparam logic [4:0] IVA_LVL_NONE = 5'h00;
	localparam logic [4:0] IVA_LVL_MASKED = 5'h1F;
	localparam logic [9:0] IVA_OFS_TOP = 10'h3FC;
	// bit k set: peripheral vector 16+k carries a resource number
	localparam logic [47:0] IVA_RESNUM_MASK = 48'h3FF3FFC3FFFF;

	// ----------------------------------------------------------------
	// extra shared sources (index 0..47: primary source of each vector)
	// ----------------------------------------------------------------
	localparam int IVA_SRC_RLT45 = 48;
	localparam int IVA_SRC_RLT6 = 49;
	localparam int IVA_SRC_SER0_I2C = 50;
	localparam int IVA_SRC_SER1_I2C = 51;
	localparam int IVA_SRC_UDC0 = 52;
	localparam int IVA_SRC_UDC1 = 53;
	localparam int IVA_SRC_HSSP_RX = 54;
	localparam int IVA_SRC_HSSP_TX = 55;
	localparam int IVA_SRC_CAL_SUB = 56;
	localparam int IVA_SRC_CAL_CR = 57;
	localparam int IVA_SRC_XBS_SBE = 58;
	localparam int IVA_SRC_BAK_SBE = 59;

	// ----------------------------------------------------------------
	// state of the top module
	// ----------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic [7:0] vec;
		logic [4:0] lvl;
		logic [31:0] addr;
		logic resnum_valid;
		logic [5:0] resnum;
		logic [47:0] vec_req;
		logic [47:0] dma_req;
	} iva_state_t;

	localparam iva_state_t IVA_STATE_RST = '0;

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	// peripheral vector index that a source feeds
	function automatic logic [5:0] iva_src_vidx(input int i);
		logic [5:0] r;
		r = 6'(i);
		case (i)
			IVA_SRC_RLT45: r = 6'h02;
			IVA_SRC_RLT6: r = 6'h03;
			IVA_SRC_SER0_I2C: r = 6'h04;
			IVA_SRC_SER1_I2C: r = 6'h06;
			IVA_SRC_UDC0, IVA_SRC_UDC1: r = 6'h14;
			IVA_SRC_HSSP_RX: r = 6'h1D;
			IVA_SRC_HSSP_TX: r = 6'h1E;
			IVA_SRC_CAL_SUB: r = 6'h1F;
			IVA_SRC_CAL_CR: r = 6'h21;
			IVA_SRC_XBS_SBE, IVA_SRC_BAK_SBE: r = 6'h2D;
			default: r = 6'(i);
		endcase
		return r;
	endfunction

	// only primary sources of vectors with a resource number may ask for dma
	function automatic logic iva_src_dma(input int i);
		return (i < IVA_NUM_PVEC) ? IVA_RESNUM_MASK[i] : 1'b0;
	endfunction

	// table offset of vector n
	function automatic logic [9:0] iva_offset(input logic [7:0] n);
		return IVA_OFS_TOP - {n, 2'b00};
	endfunction

endpackage

/* File: rtl/iva_level_select.sv */
// picks the pending peripheral vector with the most urgent level
`timescale 1ns/1ps
`default_nettype none
module iva_level_select (
	input wire logic [47:0] req_in,
	input wire logic [47:0][4:0] level_in,
	output logic found_out,
	output logic [5:0] index_out,
	output logic [4:0] level_out
);
	import iva_pkg::*;

	// ----------------------------------------------------------------
	// search: lower level value wins, ties go to the lower vector
	// ----------------------------------------------------------------
	always_comb begin
		found_out = 1'b0;
		index_out = 6'h00;
		level_out = IVA_LVL_MASKED;
		for (int i = 0; i < IVA_NUM_PVEC; i++) begin
			if (req_in[i] && level_in[i] != IVA_LVL_MASKED &&
					(!found_out || level_in[i] < level_out)) begin
				found_out = 1'b1;
				index_out = 6'(i);
				level_out = level_in[i];
			end
		end
	end

endmodule // iva_level_select
`default_nettype wire

/* File: bench/iva_src_model.sv */
// peripheral request sources facing the vector assignment block
`timescale 1ns/1ps
`default_nettype none
module iva_src_model (
	input wire logic [59:0] req_cmd_in,
	input wire logic [59:0] en_cmd_in,
	output logic [59:0] src_req_out,
	output logic [59:0] src_enable_out
);
	// level sources: lines follow the commanded pattern
	assign src_req_out = req_cmd_in;
	assign src_enable_out = en_cmd_in;
endmodule // iva_src_model
`default_nettype wire

/* File: bench/iva_vector_assign_chk.sv */
// assertions on the ports of the vector assignment block
`timescale 1ns/1ps
`default_nettype none
module iva_vector_assign_chk import iva_pkg::*; (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic [31:0] vector_table_base_in,
	input wire logic [47:0][4:0] level_control_in,
	input wire logic [59:0] src_req_in,
	input wire logic [59:0] src_enable_in,
	input wire logic swi_req_in,
	input wire logic [7:0] swi_num_in,
	input wire logic irq_valid_out,
	input wire logic [7:0] irq_vector_out,
	input wire logic [4:0] irq_level_out,
	input wire logic [31:0] irq_addr_out,
	input wire logic irq_resnum_valid_out,
	input wire logic [5:0] dma_resource_number_out,
	input wire logic [47:0] vec_req_out,
	input wire logic [47:0] dma_req_out
);
	logic [47:0][4:0] lvl_q;
	logic [59:0] act_q;
	always_ff @(posedge sys_clk_in) begin
		lvl_q <= level_control_in;
		act_q <= src_req_in & src_enable_in;
	end
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	a_addr_offset: assert property (irq_valid_out |-> irq_addr_out ==
		$past(vector_table_base_in) + 32'h3FC - {22'h0, irq_vector_out, 2'b00}) else $error("bad address");
	a_nmi_level: assert property (irq_vector_out == IVA_VEC_NMI |-> irq_valid_out &&
		irq_level_out == IVA_LVL_NMI) else $error("bad nmi level");
	a_periph_level: assert property ($past(rst_n_in) && irq_vector_out >= 8'h10 &&
		irq_vector_out < 8'h40 |-> irq_level_out == lvl_q[irq_vector_out[5:0] - 6'h10]) else $error("bad level");
	a_resnum_value: assert property (irq_resnum_valid_out |->
		IVA_RESNUM_MASK[irq_vector_out[5:0] - 6'h10] &&
		{2'b00, dma_resource_number_out} == irq_vector_out - 8'h10) else $error("bad resource number");
	a_shared_or: assert property ($past(rst_n_in) |-> vec_req_out[20] ==
		(act_q[20] | act_q[52] | act_q[53])) else $error("bad shared request");
	a_no_resnum_dma: assert property ((dma_req_out & ~IVA_RESNUM_MASK) == 48'h0) else $error("bad dma");
	a_sbe_dma: assert property ($past(rst_n_in) |-> dma_req_out[45] == act_q[45] &&
		vec_req_out[45] == (act_q[45] | act_q[58] | act_q[59])) else $error("bad ecc dma");
	a_swi_range: assert property (irq_vector_out >= IVA_VEC_SWI_FIRST |-> $past(swi_req_in) &&
		irq_vector_out == $past(swi_num_in)) else $error("bad software vector");
	c_nmi: cover property (irq_vector_out == IVA_VEC_NMI);
	c_swi: cover property (irq_vector_out >= IVA_VEC_SWI_FIRST);
	c_dma: cover property (dma_req_out[4]);
endmodule // iva_vector_assign_chk
`default_nettype wire

/* File: bench/iva_vector_assign_bench.sv */
// self-checking bench of the vector assignment block
`timescale 1ns/1ps
`default_nettype none
module iva_vector_assign_bench;
	import iva_pkg::*;
	localparam logic [11:0][5:0] XV = {6'h2D, 6'h2D, 6'h21, 6'h1F, 6'h1E, 6'h1D, 6'h14, 6'h14,
		6'h06, 6'h04, 6'h03, 6'h02};
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [59:0] r = '0;
	logic [59:0] e = '0;
	logic [59:0] src_req;
	logic [59:0] src_en;
	logic [11:0] x = '0;
	logic sw = 1'b0;
	logic [7:0] sn = '0;
	logic [31:0] b = '0;
	logic [47:0][4:0] l = '0;
	logic [31:0] seed = 32'hE4341890;
	iva_state_t q[$];
	iva_state_t w;
	logic o_valid;
	logic o_resnum_valid;
	logic [7:0] o_vec;
	logic [4:0] o_lvl;
	logic [31:0] o_addr;
	logic [5:0] o_resnum;
	logic [47:0] o_vreq;
	logic [47:0] o_dreq;
	iva_state_t seen;
	assign seen = {o_valid, o_vec, o_lvl, o_addr, o_resnum_valid, o_resnum, o_vreq, o_dreq};
	int err_total = 0;
	int num_checks = 0;
	int n;
	always #2 sys_clk = ~sys_clk;
	iva_src_model i_iva_src_model (.req_cmd_in(r), .en_cmd_in(e), .src_req_out(src_req),
		.src_enable_out(src_en));
	iva_vector_assign i_iva_vector_assign (.sys_clk_in(sys_clk), .rst_n_in(rst_n),
		.vector_table_base_in(b), .level_control_in(l), .src_req_in(src_req), .src_enable_in(src_en),
		.fpu_exc_in(x[11]), .inst_prot_in(x[10]), .data_prot_in(x[9]), .data_err_in(x[8]),
		.emulator_trap_instruction_in(x[7]), .inst_break_in(x[6]), .illegal_inst_in(x[5]),
		.user_mode_in(x[4]), .sysreg_access_in(x[3]), .nmi_req_in(x[2]), .xbs_dbl_err_in(x[1]),
		.bak_dbl_err_in(x[0]), .swi_req_in(sw), .swi_num_in(sn), .irq_valid_out(o_valid),
		.irq_vector_out(o_vec), .irq_level_out(o_lvl), .irq_addr_out(o_addr),
		.irq_resnum_valid_out(o_resnum_valid), .dma_resource_number_out(o_resnum),
		.vec_req_out(o_vreq), .dma_req_out(o_dreq));
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic iva_state_t model();
		iva_state_t s;
		logic [4:0] bl;
		logic [7:0] v;
		s = '0;
		bl = 5'h1F;
		v = 8'h00;
		for (int k = 0; k < 60; k++) begin
			if (r[k] && e[k]) begin
				s.vec_req[k < 48 ? k : XV[k - 48]] = 1'b1;
				if (k < 48)
					s.dma_req[k] = IVA_RESNUM_MASK[k];
			end
		end
		for (int k = 47; k >= 0; k--) begin
			if (s.vec_req[k] && l[k] != 5'h1F && l[k] <= bl) begin
				bl = l[k];
				v = 8'(16 + k);
			end
		end
		if (v == 8'h00 && sw && sn >= 8'h42)
			v = sn;
		if (x[2:0] != 3'b000)
			v = 8'h0F;
		if (x[5] || (x[4] && x[3]))
			v = 8'h0E;
		for (int k = 6; k < 12; k++) begin
			if (x[k])
				v = 8'(16 - k);
		end
		s.valid = v != 8'h00;
		s.vec = v;
		s.lvl = (v == 8'h0F) ? 5'h0F : (v >= 8'h10 && v < 8'h40) ? bl : 5'h00;
		s.addr = b + 32'h3FC - {22'h0, v, 2'b00};
		s.resnum_valid = v >= 8'h10 && v < 8'h40 && IVA_RESNUM_MASK[v[5:0] - 6'h10];
		s.resnum = (v >= 8'h10 && v < 8'h40) ? 6'(v - 8'h10) : 6'h00;
		return s;
	endfunction
	task chk(input string nm, input logic [63:0] s, input logic [63:0] t);
		num_checks++;
		if (s !== t) begin
			err_total++;
			$display("BAD %s exp %h seen %h", nm, t, s);
		end
	endtask
	task go();
		q.push_back(model());
		@(posedge sys_clk);
		#1;
	endtask
	task conclude();
		if (err_total == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// scoreboard: oldest note against the outputs
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		n = q.size();
		#2;
		if (n > 0) begin
			w = q.pop_front();
			chk("vector", {seen.valid, seen.vec, seen.lvl}, {w.valid, w.vec, w.lvl});
			chk("addr", {seen.addr, seen.resnum_valid, seen.resnum}, {w.addr, w.resnum_valid, w.resnum});
			chk("vreq", seen.vec_req, w.vec_req);
			chk("dma", seen.dma_req, w.dma_req);
		end
	end
	// ----------------------------------------------------------------
	// stimulus
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge sys_clk);
		#1;
		chk("reset", {seen.valid, seen.vec, seen.addr}, '0);
		rst_n = 1'b1;
		e = '1;
		b = 32'h000FFC00;
		r[7] = 1'b1;
		l[7] = 5'h03;
		go();
		r = 60'h1;
		for (int k = 0; k < 12; k++) begin
			x = 12'h001 << k;
			go();
		end
		x = 12'h018;
		go();
		x = '1;
		go();
		x = '0;
		r = '0;
		sw = 1'b1;
		for (int k = 0; k < 3; k++) begin
			sn = (k == 2) ? 8'hFF : 8'(65 + k);
			go();
		end
		sw = 1'b0;
		l = {48{5'h04}};
		for (int k = 48; k < 60; k++) begin
			r = 60'h1 << k;
			go();
		end
		r = 60'h80;
		l[7] = 5'h1F;
		go();
		for (int k = 0; k < 150; k++) begin
			r = 60'({xs(), xs()});
			e = 60'({xs(), xs()});
			for (int i = 0; i < 48; i++)
				l[i] = 5'(xs());
			b = xs();
			x = (xs() < 32'h10000000) ? 12'(xs()) : '0;
			sw = xs() > 32'h80000000;
			sn = 8'(xs());
			go();
		end
		rst_n = 1'b0;
		q.push_back('0);
		@(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		go();
		repeat (2) @(posedge sys_clk);
		conclude();
	end
	initial begin
		#4000;
		err_total++;
		conclude();
	end
endmodule // iva_vector_assign_bench
bind iva_vector_assign iva_vector_assign_chk i_iva_vector_assign_chk (
	.sys_clk_in(sys_clk_in),
	.rst_n_in(rst_n_in),
	.vector_table_base_in(vector_table_base_in),
	.level_control_in(level_control_in),
	.src_req_in(src_req_in),
	.src_enable_in(src_enable_in),
	.swi_req_in(swi_req_in),
	.swi_num_in(swi_num_in),
	.irq_valid_out(irq_valid_out),
	.irq_vector_out(irq_vector_out),
	.irq_level_out(irq_level_out),
	.irq_addr_out(irq_addr_out),
	.irq_resnum_valid_out(irq_resnum_valid_out),
	.dma_resource_number_out(dma_resource_number_out),
	.vec_req_out(vec_req_out),
	.dma_req_out(dma_req_out)
);
`default_nettype wire
